/* design/p6m_clk_if.sv */
/*
 * carrier between the pin block and its link clock generator.
 * assumes both ends run on the same block clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface p6m_clk_if;
    logic [7:0] half;
    logic run;
    logic lvl;
    logic rise;
    logic fall;

    modport gen (
        input half,
        input run,
        output lvl,
        output rise,
        output fall
    );

    modport use_clk (
        output half,
        output run,
        input lvl,
        input rise,
        input fall
    );
endinterface

`default_nettype wire

/* design/p6m_clkgen.sv */
/*
 * divider that makes the link clocks the device itself drives.
 * assumes half is held steady while run is high; rise and fall pulse in
 * the cycle the level changes.
 */
`timescale 1ns/1ps
`default_nettype none

module p6m_clkgen (
    input wire logic clk,
    input wire logic rst_b,
    p6m_clk_if.gen ck
);
    p6m_pkg::p6m_gen_t g_reg;
    p6m_pkg::p6m_gen_t g_next;

    always_comb begin
        g_next = g_reg;
        g_next.rise = 1'b0;
        g_next.fall = 1'b0;
        if (!ck.run) begin
            // parked low so the pin never shows a runt pulse
            g_next.cnt = 8'h00;
            g_next.lvl = 1'b0;
        end else if (g_reg.cnt + 8'h01 >= ck.half) begin
            g_next.cnt = 8'h00;
            g_next.lvl = ~g_reg.lvl;
            g_next.rise = ~g_reg.lvl;
            g_next.fall = g_reg.lvl;
        end else begin
            g_next.cnt = g_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            g_reg <= '0;
        end else begin
            g_reg <= g_next;
        end
    end

    assign ck.lvl = g_reg.lvl;
    assign ck.rise = g_reg.rise;
    assign ck.fall = g_reg.fall;
endmodule

`default_nettype wire

/* design/p6m_pkg.sv */
/*
 * types for the port 6 media pin block.
 * assumes p6m_regs.svh holds the matching numeric constants.
 */
`include "p6m_regs.svh"

package p6m_pkg;

    typedef enum logic [1:0] {
        MODE_MII,
        MODE_RMII,
        MODE_RGMII
    } p6m_mode_t;

    typedef enum logic [1:0] {
        SPD_10,
        SPD_100,
        SPD_1000
    } p6m_speed_t;

    typedef enum logic {
        ST_STRAP,
        ST_RUN
    } p6m_state_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic lvl;
        logic rise;
        logic fall;
    } p6m_gen_t;

    typedef struct packed {
        p6m_state_t state;
        logic [2:0] wait_cnt;
        p6m_mode_t mode;
        logic role;
        p6m_speed_t speed;
        logic [`P6M_SYNC_W-1:0] s1;
        logic [`P6M_SYNC_W-1:0] s2;
        logic [1:0] pclk;
        logic txclk_oe_b;
        logic rxclk_oe_b;
        logic [3:0] rxd_o;
        logic [3:0] rxd_oe_b;
        logic rxv_o;
        logic rxe_o;
        logic col_o;
        logic col_oe_b;
        logic crs_o;
        logic crs_oe_b;
        logic mac_rdy;
        logic [3:0] rx_data;
        logic rx_valid;
        logic rx_error;
        logic rx_stb;
        logic col_seen;
        logic crs_seen;
    } p6m_top_t;

endpackage

/* design/p6m_port6_pins.sv */
/*
 * port 6 media interface pins: mode dependent pin directions, link
 * clocks and single data rate nibble transfer in both directions.
 * assumes link clocks are far slower than REF_CLK so edges can be found
 * by sampling; two-way pins are resolved outside from the _OE_B enables.
 */
// Function
// RL1 - MII transmit clock 25 or 2.5 MHz; code makes 5 MHz in place of 25, half period clamped to one 100 ns cycle
// RL2 - MII PHY drives clocks, MAC role receives
// RL3 - RMII normal: reference clock in, rx unused
// RL4 - RMII clock mode: 50 MHz out, ignore in; code drives 5 MHz, half period clamped to one 100 ns block clock
// RL5 - RGMII transmit clock driven in by partner
// RL6 - RGMII receive clock driven out by device
// RL7 - shared transmit enable or control input
// RL8 - transmit error used only in MII
// RL9 - collision only MII, direction follows role
// RL10 - carrier sense only MII, direction follows role
// RL11 - transmit data four bits, RMII two
// RL12 - shared receive valid, carrier or control output
// RL13 - receive error output only in MII
// RL14 - receive data four bits, RMII lower two
// RL15 - receive data pins sampled as straps
// RL16 - mode and role static while traffic runs
`timescale 1ns/1ps
`default_nettype none
`include "p6m_regs.svh"

module p6m_port6_pins (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic PORT6_TRANSMIT_CLOCK_I,
    output logic PORT6_TRANSMIT_CLOCK_O,
    output logic PORT6_TRANSMIT_CLOCK_OE_B,
    input wire logic PORT6_TRANSMIT_ENABLE,
    input wire logic PORT6_TRANSMIT_ERROR,
    input wire logic [3:0] PORT6_TRANSMIT_DATA,
    input wire logic PORT6_RECEIVE_CLOCK_I,
    output logic PORT6_RECEIVE_CLOCK_O,
    output logic PORT6_RECEIVE_CLOCK_OE_B,
    output logic PORT6_RECEIVE_VALID,
    output logic PORT6_RECEIVE_ERROR,
    input wire logic [3:0] PORT6_RECEIVE_DATA_I,
    output logic [3:0] PORT6_RECEIVE_DATA_O,
    output logic [3:0] PORT6_RECEIVE_DATA_OE_B,
    input wire logic PORT6_COLLISION_DETECT_I,
    output logic PORT6_COLLISION_DETECT_O,
    output logic PORT6_COLLISION_DETECT_OE_B,
    input wire logic PORT6_CARRIER_SENSE_I,
    output logic PORT6_CARRIER_SENSE_O,
    output logic PORT6_CARRIER_SENSE_OE_B,
    input wire logic [1:0] SPEED_SEL,
    input wire logic [3:0] MAC_TX_DATA,
    input wire logic MAC_TX_VALID,
    input wire logic MAC_TX_ERROR,
    output logic MAC_TX_READY,
    input wire logic MAC_COL,
    input wire logic MAC_CRS,
    output logic [3:0] RX_DATA_OUT,
    output logic RX_VALID_OUT,
    output logic RX_ERROR_OUT,
    output logic RX_STROBE_OUT,
    output logic COL_SEEN,
    output logic CRS_SEEN,
    output logic [1:0] MODE_OUT,
    output logic ROLE_OUT,
    output logic STRAP_DONE
);
    p6m_pkg::p6m_top_t r_reg;
    p6m_pkg::p6m_top_t r_next;
    p6m_clk_if ck ();

    logic [`P6M_SYNC_W-1:0] pins_in;
    logic mii, rmii, rgmii, mii_phy, mii_mac, rmii_clk, dev_clk;
    logic tx_rise, tx_fall, rx_fall, cap_edge, launch_edge;

    assign pins_in = {PORT6_RECEIVE_DATA_I, PORT6_TRANSMIT_DATA,
                      PORT6_CARRIER_SENSE_I, PORT6_COLLISION_DETECT_I,
                      PORT6_TRANSMIT_ERROR, PORT6_TRANSMIT_ENABLE,
                      PORT6_RECEIVE_CLOCK_I, PORT6_TRANSMIT_CLOCK_I};

    assign mii = r_reg.mode == p6m_pkg::MODE_MII;
    assign rmii = r_reg.mode == p6m_pkg::MODE_RMII;
    assign rgmii = r_reg.mode == p6m_pkg::MODE_RGMII;
    assign mii_phy = mii & r_reg.role;
    assign mii_mac = mii & ~r_reg.role;
    assign rmii_clk = rmii & r_reg.role;
    // clocks the device makes itself
    assign dev_clk = mii_phy | rmii_clk | rgmii; // [RL2] [RL4] [RL6]

    // edges of the partner clocks, seen after the second sync stage
    assign tx_rise = r_reg.s2[`P6M_IX_TXCLK] & ~r_reg.pclk[0];
    assign tx_fall = ~r_reg.s2[`P6M_IX_TXCLK] & r_reg.pclk[0];
    assign rx_fall = ~r_reg.s2[`P6M_IX_RXCLK] & r_reg.pclk[1];

    // RMII clock mode and MII PHY sample on the device clock; the input
    // reference pin is then ignored
    assign cap_edge = (mii_phy | rmii_clk) ? ck.rise : tx_rise; // [RL3] [RL4] [RL5]
    assign launch_edge = dev_clk ? ck.fall :
                         (mii_mac ? rx_fall : tx_fall); // [RL2] [RL3]

    always_comb begin
        if (rgmii) begin
            case (r_reg.speed)
                p6m_pkg::SPD_1000: ck.half = 8'(`P6M_HALF_125); // [RL6]
                p6m_pkg::SPD_100: ck.half = 8'(`P6M_HALF_25);
                default: ck.half = 8'(`P6M_HALF_2P5);
            endcase
        end else if (rmii) begin
            ck.half = 8'(`P6M_HALF_50); // [RL4]
        end else if (r_reg.speed == p6m_pkg::SPD_10) begin
            ck.half = 8'(`P6M_HALF_2P5); // [RL1]
        end else begin
            ck.half = 8'(`P6M_HALF_25); // [RL1]
        end
    end
    assign ck.run = (r_reg.state == p6m_pkg::ST_RUN) & dev_clk;

    p6m_clkgen u_clkgen (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .ck(ck)
    );

    always_comb begin
        r_next = r_reg;
        r_next.s1 = pins_in;
        r_next.s2 = r_reg.s1;
        r_next.pclk = {r_reg.s2[`P6M_IX_RXCLK], r_reg.s2[`P6M_IX_TXCLK]};
        r_next.rx_stb = 1'b0;
        r_next.mac_rdy = 1'b0;
        case (r_reg.state)
            p6m_pkg::ST_STRAP: begin
                // pins released so the pull resistors show the straps
                r_next.wait_cnt = r_reg.wait_cnt + 3'h1;
                if (r_reg.wait_cnt == `P6M_STRAP_WAIT) begin
                    case (r_reg.s2[`P6M_IX_RXD+`P6M_STRAP_MODE_LSB +: 2])
                        `P6M_STRAP_MII: r_next.mode = p6m_pkg::MODE_MII;
                        `P6M_STRAP_RMII: r_next.mode = p6m_pkg::MODE_RMII;
                        default: r_next.mode = p6m_pkg::MODE_RGMII;
                    endcase // [RL15]
                    r_next.role = r_reg.s2[`P6M_IX_RXD+`P6M_STRAP_ROLE_BIT];
                    r_next.state = p6m_pkg::ST_RUN;
                end
            end
            p6m_pkg::ST_RUN: begin
                // mode and role never change here; speed only between
                // frames so a clock never switches rate mid nibble
                if (!r_reg.s2[`P6M_IX_TXEN] && !MAC_TX_VALID &&
                    !r_reg.rxv_o) begin
                    case (SPEED_SEL)
                        `P6M_SPD_SEL_10: r_next.speed = p6m_pkg::SPD_10;
                        `P6M_SPD_SEL_100: r_next.speed = p6m_pkg::SPD_100;
                        default: r_next.speed = p6m_pkg::SPD_1000;
                    endcase // [RL16]
                end
                r_next.txclk_oe_b = ~mii_phy; // [RL2] [RL3] [RL5]
                r_next.rxclk_oe_b = ~dev_clk; // [RL2] [RL4] [RL6]
                r_next.rxd_oe_b = rmii ? 4'hC : 4'h0; // [RL14]
                r_next.col_oe_b = ~mii_phy; // [RL9]
                r_next.crs_oe_b = ~mii_phy; // [RL10]
                r_next.col_o = mii_phy & MAC_COL; // [RL9]
                r_next.crs_o = mii_phy & MAC_CRS; // [RL10]
                r_next.col_seen = mii_mac & r_reg.s2[`P6M_IX_COL]; // [RL9]
                r_next.crs_seen = mii_mac & r_reg.s2[`P6M_IX_CRS]; // [RL10]
                if (cap_edge) begin
                    r_next.rx_stb = 1'b1;
                    r_next.rx_data = r_reg.s2[`P6M_IX_TXD +: 4] &
                                     (rmii ? 4'h3 : 4'hF); // [RL11]
                    r_next.rx_valid = r_reg.s2[`P6M_IX_TXEN]; // [RL7]
                    r_next.rx_error = mii & r_reg.s2[`P6M_IX_TXER]; // [RL8]
                end
                if (launch_edge) begin
                    r_next.mac_rdy = MAC_TX_VALID;
                    r_next.rxv_o = MAC_TX_VALID; // [RL12]
                    r_next.rxe_o = mii & MAC_TX_VALID & MAC_TX_ERROR; // [RL13]
                    r_next.rxd_o = MAC_TX_VALID ?
                        (MAC_TX_DATA & (rmii ? 4'h3 : 4'hF)) : 4'h0; // [RL14]
                end
            end
            default: r_next.state = p6m_pkg::ST_STRAP;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            r_reg <= '0;
            r_reg.state <= p6m_pkg::ST_STRAP;
            r_reg.speed <= p6m_pkg::SPD_100;
            r_reg.txclk_oe_b <= 1'b1;
            r_reg.rxclk_oe_b <= 1'b1;
            r_reg.rxd_oe_b <= 4'hF;
            r_reg.col_oe_b <= 1'b1;
            r_reg.crs_oe_b <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign PORT6_TRANSMIT_CLOCK_O = ck.lvl;
    assign PORT6_TRANSMIT_CLOCK_OE_B = r_reg.txclk_oe_b;
    assign PORT6_RECEIVE_CLOCK_O = ck.lvl;
    assign PORT6_RECEIVE_CLOCK_OE_B = r_reg.rxclk_oe_b;
    assign PORT6_RECEIVE_VALID = r_reg.rxv_o;
    assign PORT6_RECEIVE_ERROR = r_reg.rxe_o;
    assign PORT6_RECEIVE_DATA_O = r_reg.rxd_o;
    assign PORT6_RECEIVE_DATA_OE_B = r_reg.rxd_oe_b;
    assign PORT6_COLLISION_DETECT_O = r_reg.col_o;
    assign PORT6_COLLISION_DETECT_OE_B = r_reg.col_oe_b;
    assign PORT6_CARRIER_SENSE_O = r_reg.crs_o;
    assign PORT6_CARRIER_SENSE_OE_B = r_reg.crs_oe_b;
    assign MAC_TX_READY = r_reg.mac_rdy;
    assign RX_DATA_OUT = r_reg.rx_data;
    assign RX_VALID_OUT = r_reg.rx_valid;
    assign RX_ERROR_OUT = r_reg.rx_error;
    assign RX_STROBE_OUT = r_reg.rx_stb;
    assign COL_SEEN = r_reg.col_seen;
    assign CRS_SEEN = r_reg.crs_seen;
    assign MODE_OUT = r_reg.mode;
    assign ROLE_OUT = r_reg.role;
    assign STRAP_DONE = r_reg.state == p6m_pkg::ST_RUN;
endmodule

`default_nettype wire

/* design/p6m_regs.svh */
/*
 * constants for the port 6 media pin block: clock periods, divider
 * counts, strap bit positions, speed select codes and the index of each
 * pin in the synchroniser vector.
 * assumes the block clock period below matches REF_CLK.
 */
`ifndef P6M_REGS_SVH
`define P6M_REGS_SVH

`define P6M_CLK_NS 100

// link clock periods in ns
`define P6M_PER_125_NS 8
`define P6M_PER_50_NS 20
`define P6M_PER_25_NS 40
`define P6M_PER_2P5_NS 400

// half period in block clocks, rounded down, never below one cycle
`define P6M_HALF(p) (((p) / 2 / `P6M_CLK_NS) > 0 ? ((p) / 2 / `P6M_CLK_NS) : 1)
`define P6M_HALF_125 `P6M_HALF(`P6M_PER_125_NS)
`define P6M_HALF_50 `P6M_HALF(`P6M_PER_50_NS)
`define P6M_HALF_25 `P6M_HALF(`P6M_PER_25_NS)
`define P6M_HALF_2P5 `P6M_HALF(`P6M_PER_2P5_NS)

// strap layout on the receive data pins
`define P6M_STRAP_MODE_LSB 0
`define P6M_STRAP_ROLE_BIT 2
`define P6M_STRAP_WAIT 3'h3
`define P6M_STRAP_MII 2'h0
`define P6M_STRAP_RMII 2'h1

// speed select codes
`define P6M_SPD_SEL_10 2'h0
`define P6M_SPD_SEL_100 2'h1

// synchroniser vector layout
`define P6M_SYNC_W 14
`define P6M_IX_TXCLK 0
`define P6M_IX_RXCLK 1
`define P6M_IX_TXEN 2
`define P6M_IX_TXER 3
`define P6M_IX_COL 4
`define P6M_IX_CRS 5
`define P6M_IX_TXD 6
`define P6M_IX_RXD 10

`endif

/* tb/p6m_chk.sv */
/*
 * checker for the port 6 media pin block, bound to its top module.
 * assumes straps are read once per reset and enables settle one edge
 * after STRAP_DONE rises.
 */
`timescale 1ns/1ps
`default_nettype none

module p6m_chk (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic PORT6_TRANSMIT_CLOCK_OE_B,
    input wire logic PORT6_RECEIVE_CLOCK_OE_B,
    input wire logic PORT6_RECEIVE_VALID,
    input wire logic PORT6_RECEIVE_ERROR,
    input wire logic [3:0] PORT6_RECEIVE_DATA_O,
    input wire logic [3:0] PORT6_RECEIVE_DATA_OE_B,
    input wire logic PORT6_COLLISION_DETECT_OE_B,
    input wire logic PORT6_CARRIER_SENSE_OE_B,
    input wire logic MAC_TX_VALID,
    input wire logic MAC_TX_READY,
    input wire logic [3:0] RX_DATA_OUT,
    input wire logic RX_ERROR_OUT,
    input wire logic RX_STROBE_OUT,
    input wire logic [1:0] MODE_OUT,
    input wire logic ROLE_OUT,
    input wire logic STRAP_DONE
);
    logic phy;
    assign phy = MODE_OUT == 2'h0 && ROLE_OUT;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);
    // $past of done guards the one edge where enables still lag
    tx_clk_dir_a:
        assert property ($past(STRAP_DONE) |->
            PORT6_TRANSMIT_CLOCK_OE_B == !phy) else $error("tx clock dir");
    rx_clk_dir_a:
        assert property ($past(STRAP_DONE) |-> PORT6_RECEIVE_CLOCK_OE_B ==
            !(phy || MODE_OUT == 2'h2 || (MODE_OUT == 2'h1 && ROLE_OUT)))
            else $error("rx clock dir");
    side_dir_a:
        assert property ($past(STRAP_DONE) |-> PORT6_COLLISION_DETECT_OE_B
            == !phy && PORT6_CARRIER_SENSE_OE_B == !phy)
            else $error("col crs dir");
    err_unused_a:
        assert property (MODE_OUT != 2'h0 |-> !PORT6_RECEIVE_ERROR &&
            !RX_ERROR_OUT) else $error("error used outside mii");
    rmii_upper_a:
        assert property (MODE_OUT == 2'h1 |-> PORT6_RECEIVE_DATA_O[3:2] ==
            2'h0 && RX_DATA_OUT[3:2] == 2'h0) else $error("rmii upper bits");
    strap_hiz_a:
        assert property (!STRAP_DONE |-> PORT6_RECEIVE_DATA_OE_B == 4'hF)
            else $error("rx data driven during strap");
    rxd_dir_a:
        assert property ($past(STRAP_DONE) |-> PORT6_RECEIVE_DATA_OE_B ==
            (MODE_OUT == 2'h1 ? 4'hC : 4'h0)) else $error("rx data dir");
    tx_ready_a:
        assert property (MAC_TX_READY |-> ($past(MAC_TX_VALID) &&
            PORT6_RECEIVE_VALID) ##1 !MAC_TX_READY) else $error("ready");
    mode_static_a:
        assert property ($past(STRAP_DONE) |-> $stable(MODE_OUT) &&
            $stable(ROLE_OUT)) else $error("mode changed in run");
    strobe_one_a:
        assert property (RX_STROBE_OUT |=> !RX_STROBE_OUT)
            else $error("strobe too long");
endmodule

bind p6m_port6_pins p6m_chk i_chk (.*);

`default_nettype wire

/* tb/p6m_partner.sv */
/*
 * far side link partner: makes its own 800 ns link clock and launches
 * transmit pins on the falling edge of whichever clock owns the link.
 * assumes the bench resolves two-way pins from the device enables.
 */
`timescale 1ns/1ps
`default_nettype none

module p6m_partner (
    input wire logic [1:0] mode,
    input wire logic tx_oe_b,
    input wire logic tx_o,
    input wire logic rx_oe_b,
    input wire logic rx_o,
    input wire logic [3:0] req_d,
    input wire logic req_en,
    input wire logic req_er,
    output logic own_clk,
    output logic [3:0] txd,
    output logic txen,
    output logic txer
);
    logic lc;
    initial own_clk = 1'b0;
    initial {txd, txen, txer} = 6'h00;
    // mii clocks run free, so no stop between frames
    always #400 own_clk = !own_clk;
    // follow the device clock where it owns the link
    assign lc = !tx_oe_b ? tx_o : (mode == 2'h1 && !rx_oe_b) ? rx_o : own_clk;
    // error is driven even where unused so the bench can see it ignored
    always @(negedge lc) begin
        txd <= req_d;
        txen <= req_en;
        txer <= req_er;
    end
endmodule

`default_nettype wire

/* tb/testbench.sv */
/*
 * self-checking bench for the port 6 media pin block.
 * assumes the partner model and the bound checker compile first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "p6m_regs.svh"

module testbench;
    logic REF_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [1:0] SPEED_SEL = 2'h0;
    logic [3:0] MAC_TX_DATA = 4'h0;
    logic MAC_TX_VALID = 1'b0, MAC_TX_ERROR = 1'b0;
    logic MAC_COL = 1'b0, MAC_CRS = 1'b0;
    logic [3:0] strap = 4'h0, rq_d = 4'h0;
    logic rq_en = 1'b0, rq_er = 1'b0, pcs = 1'b0, own_clk;
    logic PORT6_TRANSMIT_CLOCK_I, PORT6_TRANSMIT_CLOCK_O;
    logic PORT6_TRANSMIT_CLOCK_OE_B, PORT6_TRANSMIT_ENABLE;
    logic PORT6_TRANSMIT_ERROR, PORT6_RECEIVE_CLOCK_I;
    logic PORT6_RECEIVE_CLOCK_O, PORT6_RECEIVE_CLOCK_OE_B;
    logic PORT6_RECEIVE_VALID, PORT6_RECEIVE_ERROR;
    logic [3:0] PORT6_TRANSMIT_DATA, PORT6_RECEIVE_DATA_I;
    logic [3:0] PORT6_RECEIVE_DATA_O, PORT6_RECEIVE_DATA_OE_B;
    logic PORT6_COLLISION_DETECT_I, PORT6_COLLISION_DETECT_O;
    logic PORT6_COLLISION_DETECT_OE_B, PORT6_CARRIER_SENSE_I;
    logic PORT6_CARRIER_SENSE_O, PORT6_CARRIER_SENSE_OE_B;
    logic MAC_TX_READY, RX_VALID_OUT, RX_ERROR_OUT, RX_STROBE_OUT;
    logic [3:0] RX_DATA_OUT;
    logic COL_SEEN, CRS_SEEN, ROLE_OUT, STRAP_DONE;
    logic [1:0] MODE_OUT;
    logic dev_ck;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    logic [3:0] cfg [5] = '{4'h0, 4'h4, 4'h1, 4'h5, 4'h2};

    p6m_port6_pins i_p6m_port6_pins (.*);
    p6m_partner i_p6m_partner (
        .mode(strap[1:0]),
        .tx_oe_b(PORT6_TRANSMIT_CLOCK_OE_B),
        .tx_o(PORT6_TRANSMIT_CLOCK_O),
        .rx_oe_b(PORT6_RECEIVE_CLOCK_OE_B),
        .rx_o(PORT6_RECEIVE_CLOCK_O),
        .req_d(rq_d),
        .req_en(rq_en),
        .req_er(rq_er),
        .own_clk(own_clk),
        .txd(PORT6_TRANSMIT_DATA),
        .txen(PORT6_TRANSMIT_ENABLE),
        .txer(PORT6_TRANSMIT_ERROR)
    );
    // the partner toggles clock pins even where unused, to prove them ignored
    assign PORT6_TRANSMIT_CLOCK_I = PORT6_TRANSMIT_CLOCK_OE_B ?
        own_clk : PORT6_TRANSMIT_CLOCK_O;
    assign PORT6_RECEIVE_CLOCK_I = PORT6_RECEIVE_CLOCK_OE_B ?
        own_clk : PORT6_RECEIVE_CLOCK_O;
    // strap pins fall to their pull-down once the straps are taken
    assign PORT6_RECEIVE_DATA_I = (PORT6_RECEIVE_DATA_OE_B &
        (STRAP_DONE ? 4'h0 : strap)) |
        (~PORT6_RECEIVE_DATA_OE_B & PORT6_RECEIVE_DATA_O);
    assign PORT6_COLLISION_DETECT_I = PORT6_COLLISION_DETECT_OE_B ?
        pcs : PORT6_COLLISION_DETECT_O;
    assign PORT6_CARRIER_SENSE_I = PORT6_CARRIER_SENSE_OE_B ?
        pcs : PORT6_CARRIER_SENSE_O;
    // rgmii drives its clock on the receive pin, mii phy on the transmit pin
    assign dev_ck = MODE_OUT == 2'h2 ? PORT6_RECEIVE_CLOCK_O :
        PORT6_TRANSMIT_CLOCK_O;

    always #50 REF_CLK = !REF_CLK;

    task automatic chk(string nm, logic [3:0] got, logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge REF_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic wait_stb();
        do @(negedge REF_CLK); while (RX_STROBE_OUT !== 1'b1);
    endtask

    task automatic do_reset(logic [3:0] s);
        @(posedge REF_CLK);
        RST_B <= 1'b0;
        strap <= s;
        repeat (4) @(posedge REF_CLK);
        RST_B <= 1'b1;
        repeat (8) @(negedge REF_CLK);
        chk("strap done", STRAP_DONE, 1'b1);
    endtask

    task automatic t_pins(logic [1:0] m, logic r);
        logic phy;
        phy = m == 2'h0 && r;
        chk("mode", MODE_OUT, m);
        chk("role", ROLE_OUT, r);
        chk("txclk oe", PORT6_TRANSMIT_CLOCK_OE_B, !phy);
        chk("rxclk oe", PORT6_RECEIVE_CLOCK_OE_B, !(phy || m[1] || r));
        chk("col oe", PORT6_COLLISION_DETECT_OE_B, !phy);
        chk("crs oe", PORT6_CARRIER_SENSE_OE_B, !phy);
        chk("rxd oe", PORT6_RECEIVE_DATA_OE_B, m == 2'h1 ? 4'hC : 4'h0);
    endtask

    task automatic t_rx(logic [1:0] m, logic [3:0] d, logic en, logic er);
        @(posedge REF_CLK);
        rq_d <= d;
        rq_en <= en;
        rq_er <= er;
        repeat (3) wait_stb();
        chk("rx data", RX_DATA_OUT, m == 2'h1 ? d & 4'h3 : d);
        chk("rx valid", RX_VALID_OUT, en);
        chk("rx err", RX_ERROR_OUT, er && m == 2'h0);
    endtask

    task automatic t_tx(logic [1:0] m);
        @(posedge REF_CLK);
        MAC_TX_DATA <= 4'hE;
        MAC_TX_VALID <= 1'b1;
        MAC_TX_ERROR <= 1'b1;
        do @(negedge REF_CLK); while (MAC_TX_READY !== 1'b1);
        chk("pin data", PORT6_RECEIVE_DATA_O, m == 2'h1 ? 4'h2 : 4'hE);
        chk("pin valid", PORT6_RECEIVE_VALID, 1'b1);
        chk("pin err", PORT6_RECEIVE_ERROR, m == 2'h0);
        @(posedge REF_CLK);
        MAC_TX_VALID <= 1'b0;
        MAC_TX_ERROR <= 1'b0;
    endtask

    task automatic t_side(logic [1:0] m, logic r);
        @(posedge REF_CLK);
        MAC_COL <= 1'b1;
        MAC_CRS <= 1'b1;
        pcs <= 1'b1;
        repeat (5) @(negedge REF_CLK);
        // a driven pin must carry the level; an undriven one is don't care
        chk("col crs out", {PORT6_COLLISION_DETECT_O |
            PORT6_COLLISION_DETECT_OE_B, PORT6_CARRIER_SENSE_O |
            PORT6_CARRIER_SENSE_OE_B}, 4'h3);
        chk("col crs seen", {COL_SEEN, CRS_SEEN}, {2{m == 2'h0 && !r}});
        @(posedge REF_CLK);
        MAC_COL <= 1'b0;
        MAC_CRS <= 1'b0;
        pcs <= 1'b0;
    endtask

    task automatic t_speed(logic [1:0] s, int half);
        realtime t0;
        logic [3:0] n;
        @(posedge REF_CLK);
        SPEED_SEL <= s;
        repeat (10) @(posedge REF_CLK);
        @(posedge dev_ck);
        t0 = $realtime;
        @(posedge dev_ck);
        n = 4'(int'(($realtime - t0) / 100.0));
        chk("clk period", n, 4'(2 * half));
        $display("speed test %0d done", s);
    endtask

    initial begin
        foreach (cfg[i]) begin
            do_reset(cfg[i]);
            t_pins(cfg[i][1:0], cfg[i][2]);
            t_rx(cfg[i][1:0], 4'hA, 1'b1, 1'b1);
            t_rx(cfg[i][1:0], 4'h5, 1'b0, 1'b0);
            t_tx(cfg[i][1:0]);
            t_side(cfg[i][1:0], cfg[i][2]);
            $display("mode test %h done", cfg[i]);
        end
        do_reset(4'h4);
        t_speed(2'h1, `P6M_HALF_25);
        t_speed(2'h0, `P6M_HALF_2P5);
        do_reset(4'h2);
        t_speed(2'h2, `P6M_HALF_125);
        t_speed(2'h0, `P6M_HALF_2P5);
        print_verdict();
    end
endmodule

`default_nettype wire
